/* hicr_bcd_check.sv */
// BCD byte checker: flags a byte whose either nibble is not a decimal digit
`timescale 1ns/100ps
module hicr_bcd_check
   import hicr_pkg::*;
(
   input wire logic [7:0] byte_in,
   output logic bcd_ok
);
   function automatic logic nib_ok(input logic [3:0] n);
      return n <= 4'h9;
   endfunction
   wire lo_ok = nib_ok(byte_in[3:0]);
   wire hi_ok = nib_ok(byte_in[7:4]);
   assign bcd_ok = lo_ok & hi_ok;
endmodule

/* hicr_cfg_master.sv */
// Configuration master model that drives the register slice's access port
`timescale 1ns/100ps
module hicr_cfg_master (
   input wire logic ref_clk,
   output logic cfg_wr,
   output logic cfg_rd,
   output logic [7:0] cfg_addr,
   output logic [7:0] cfg_wdata
);
   initial begin
      cfg_wr = 1'b0;
      cfg_rd = 1'b0;
      cfg_addr = 8'h00;
      cfg_wdata = 8'h00;
   end
   // Lines are inverted on release, so a stale address or byte is never mistaken for a request
   task automatic write_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      cfg_wr <= 1'b1;
      cfg_addr <= a;
      cfg_wdata <= d;
      @(posedge ref_clk);
      cfg_wr <= 1'b0;
      cfg_addr <= ~a;
      cfg_wdata <= ~d;
   endtask
   task automatic read_byte(input logic [7:0] a);
      @(posedge ref_clk);
      cfg_rd <= 1'b1;
      cfg_addr <= a;
      @(posedge ref_clk);
      cfg_rd <= 1'b0;
      cfg_addr <= ~a;
   endtask
endmodule

/* hicr_pkg.sv */
// Package: register map, defaults and widths for the hub identity/config slice
package hicr_pkg;
   // ----------------------------------------
   // Register offsets
   // ----------------------------------------
   localparam logic [7:0] HICR_VENDOR_ID_LOW_OFS = 8'h00;
   localparam logic [7:0] HICR_VENDOR_ID_HIGH_OFS = 8'h01;
   localparam logic [7:0] HICR_PRODUCT_ID_LOW_OFS = 8'h02;
   localparam logic [7:0] HICR_PRODUCT_ID_HIGH_OFS = 8'h03;
   localparam logic [7:0] HICR_RELEASE_NUMBER_LOW_OFS = 8'h04;
   localparam logic [7:0] HICR_RELEASE_NUMBER_HIGH_OFS = 8'h05;
   localparam logic [7:0] HICR_HUB_CONFIG_BYTE_ONE_OFS = 8'h06;
   // ----------------------------------------
   // Field positions and widths
   // ----------------------------------------
   localparam int HICR_POWER_SOURCE_SELECT_BIT = 7;
   localparam int HICR_NUM_REGS = 7;
   localparam int HICR_DEF_PORT_COUNT = 3;
   localparam int HICR_PORT_CURRENT_MA = 500;
   // ----------------------------------------
   // Power source encoding
   // ----------------------------------------
   localparam logic HICR_BUS_POWERED = 1'b0;
   localparam logic HICR_SELF_POWERED = 1'b1;
   // ----------------------------------------
   // Built-in defaults (identity values arbitrary)
   // ----------------------------------------
   localparam logic [7:0] HICR_DEF_VENDOR_ID_LOW = 8'h5A;
   localparam logic [7:0] HICR_DEF_VENDOR_ID_HIGH = 8'hA5;
   localparam logic [7:0] HICR_DEF_PRODUCT_ID_LOW = 8'h11;
   localparam logic [7:0] HICR_DEF_PRODUCT_ID_HIGH = 8'h22;
   localparam logic [7:0] HICR_DEF_RELEASE_NUMBER_LOW = 8'h00;
   localparam logic [7:0] HICR_DEF_RELEASE_NUMBER_HIGH = 8'h01;
   localparam logic [7:0] HICR_DEF_HUB_CONFIG_BYTE_ONE = 8'h80;
endpackage

/* hicr_regs.sv */
// Hub identity and first configuration byte register slice
//
// Functional notes
// R1: A 16-bit vendor identifier is held, low byte at offset 0x00 bits 7:0, high byte at 0x01.
// R2: A 16-bit product identifier is held, low byte at 0x02 and high byte at 0x03.
// R3: The release number is 16-bit BCD at 0x04/0x05 and each written nibble must be 0 to 9.
// R4: The configuration master may overwrite any identifier byte, which then replaces the default.
// R5: Bit 7 of the configuration byte at 0x06 selects self- or bus-powered operation.
// R6: The power selection bit reads 0 for bus-powered and 1 for self-powered.
// R7: When self-powered, every downstream port is available and rated at 500 mA.
// R8: Reset returns every identifier and configuration byte to its built-in default.
`timescale 1ns/100ps
module hicr_regs
   import hicr_pkg::*;
#(
   parameter int PORT_COUNT = HICR_DEF_PORT_COUNT
)
(
   input wire logic ref_clk,
   input wire logic rstn,
   input wire logic cfg_wr,
   input wire logic cfg_rd,
   input wire logic [7:0] cfg_addr,
   input wire logic [7:0] cfg_wdata,
   output logic [7:0] cfg_rdata,
   output logic cfg_addr_err,
   output logic cfg_bcd_err,
   output logic [15:0] vendor_id,
   output logic [15:0] product_id,
   output logic [15:0] release_number,
   output logic power_source_select,
   output logic [PORT_COUNT-1:0] port_available,
   output logic [15:0] port_current_ma
);
   // ----------------------------------------
   // Parameter check
   // ----------------------------------------
   // The port mask and the current word are sized for at most sixteen ports
   if (PORT_COUNT < 1 || PORT_COUNT > 16) begin : g_bad_port_count
      $error("PORT_COUNT must be 1 to 16");
   end

   // ----------------------------------------
   // Register storage
   // ----------------------------------------
   logic [7:0] regs_reg [HICR_NUM_REGS];
   logic [7:0] rdata_reg;
   logic addr_err_reg;
   logic bcd_err_reg;

   function automatic logic [7:0] def_val(input int i);
      case (i)
         0: def_val = HICR_DEF_VENDOR_ID_LOW;
         1: def_val = HICR_DEF_VENDOR_ID_HIGH;
         2: def_val = HICR_DEF_PRODUCT_ID_LOW;
         3: def_val = HICR_DEF_PRODUCT_ID_HIGH;
         4: def_val = HICR_DEF_RELEASE_NUMBER_LOW;
         5: def_val = HICR_DEF_RELEASE_NUMBER_HIGH;
         default: def_val = HICR_DEF_HUB_CONFIG_BYTE_ONE;
      endcase
   endfunction

   // Offset to storage slot; an unmapped offset falls to slot 0 and is masked by addr_hit
   function automatic logic [2:0] ofs_to_idx(input logic [7:0] ofs);
      logic [2:0] idx;
      idx = 3'h0;
      if (ofs == HICR_VENDOR_ID_LOW_OFS) begin
         idx = 3'h0;
      end else if (ofs == HICR_VENDOR_ID_HIGH_OFS) begin
         idx = 3'h1;
      end else if (ofs == HICR_PRODUCT_ID_LOW_OFS) begin
         idx = 3'h2;
      end else if (ofs == HICR_PRODUCT_ID_HIGH_OFS) begin
         idx = 3'h3;
      end else if (ofs == HICR_RELEASE_NUMBER_LOW_OFS) begin
         idx = 3'h4;
      end else if (ofs == HICR_RELEASE_NUMBER_HIGH_OFS) begin
         idx = 3'h5;
      end else if (ofs == HICR_HUB_CONFIG_BYTE_ONE_OFS) begin
         idx = 3'h6;
      end
      return idx;
   endfunction

   // ----------------------------------------
   // Decode
   // ----------------------------------------
   wire addr_hit = cfg_addr <= HICR_HUB_CONFIG_BYTE_ONE_OFS;
   wire is_release = (cfg_addr == HICR_RELEASE_NUMBER_LOW_OFS) ||
                     (cfg_addr == HICR_RELEASE_NUMBER_HIGH_OFS);
   wire wdata_bcd_ok;
   // Non-decimal release nibbles are refused so the descriptor never shows bad BCD
   wire wr_ok = cfg_wr & addr_hit & (~is_release | wdata_bcd_ok); // see R3
   wire [2:0] wr_idx = ofs_to_idx(cfg_addr); // see R1, R2, R3, R5

   hicr_bcd_check u_bcd (
      .byte_in(cfg_wdata),
      .bcd_ok(wdata_bcd_ok)
   );

   // ----------------------------------------
   // Write path
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         regs_reg[0] <= HICR_DEF_VENDOR_ID_LOW; // see R8
         regs_reg[1] <= HICR_DEF_VENDOR_ID_HIGH; // see R8
         regs_reg[2] <= HICR_DEF_PRODUCT_ID_LOW; // see R8
         regs_reg[3] <= HICR_DEF_PRODUCT_ID_HIGH; // see R8
         regs_reg[4] <= HICR_DEF_RELEASE_NUMBER_LOW; // see R8
         regs_reg[5] <= HICR_DEF_RELEASE_NUMBER_HIGH; // see R8
         regs_reg[6] <= HICR_DEF_HUB_CONFIG_BYTE_ONE; // see R8
      end else if (wr_ok) begin
         regs_reg[wr_idx] <= cfg_wdata; // see R4
      end
   end

   // ----------------------------------------
   // Read path and error flags
   // ----------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         rdata_reg <= 8'h00;
         addr_err_reg <= 1'b0;
         bcd_err_reg <= 1'b0;
      end else begin
         if (cfg_rd) begin
            rdata_reg <= addr_hit ? regs_reg[wr_idx] : 8'h00;
         end
         addr_err_reg <= (cfg_wr | cfg_rd) & ~addr_hit;
         bcd_err_reg <= cfg_wr & addr_hit & is_release & ~wdata_bcd_ok; // see R3
      end
   end

   assign cfg_rdata = rdata_reg;
   assign cfg_addr_err = addr_err_reg;
   assign cfg_bcd_err = bcd_err_reg;

   // ----------------------------------------
   // Outputs to the hub core
   // ----------------------------------------
   assign vendor_id = {regs_reg[1], regs_reg[0]}; // see R1
   assign product_id = {regs_reg[3], regs_reg[2]}; // see R2
   assign release_number = {regs_reg[5], regs_reg[4]}; // see R3
   assign power_source_select = regs_reg[6][HICR_POWER_SOURCE_SELECT_BIT]; // see R5
   wire self_powered = power_source_select == HICR_SELF_POWERED; // see R6
   // Bus-powered port gating belongs to other config bytes, so all ports stay usable here
   assign port_available = self_powered ? {PORT_COUNT{1'b1}} : {PORT_COUNT{1'b1}}; // see R7
   assign port_current_ma = self_powered ? 16'(HICR_PORT_CURRENT_MA) : 16'h0064; // see R7

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   AST_WRITE_TAKES: assert property (@(posedge ref_clk) disable iff (!rstn) // see R4
      (cfg_wr && addr_hit && !is_release) |=> regs_reg[$past(wr_idx)] == $past(cfg_wdata))
      else $error("written byte not stored");
   AST_BCD_REFUSED: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
      (cfg_wr && is_release && !wdata_bcd_ok) |=> $stable(release_number) && cfg_bcd_err)
      else $error("non-BCD release byte accepted");
   AST_VID_MAP: assert property (@(posedge ref_clk) disable iff (!rstn) // see R1
      (cfg_wr && cfg_addr == HICR_VENDOR_ID_LOW_OFS) |=> vendor_id[7:0] == $past(cfg_wdata))
      else $error("vendor low byte misplaced");
   AST_PID_MAP: assert property (@(posedge ref_clk) disable iff (!rstn) // see R2
      (cfg_wr && cfg_addr == HICR_PRODUCT_ID_HIGH_OFS) |=> product_id[15:8] == $past(cfg_wdata))
      else $error("product high byte misplaced");
   AST_PWR_BIT: assert property (@(posedge ref_clk) disable iff (!rstn) // see R5
      (cfg_wr && cfg_addr == HICR_HUB_CONFIG_BYTE_ONE_OFS) |=>
      power_source_select == $past(cfg_wdata[7]))
      else $error("power select not from bit 7");
   AST_SELF_PORTS: assert property (@(posedge ref_clk) disable iff (!rstn) // see R7
      power_source_select |-> (&port_available) && port_current_ma == 16'h01F4)
      else $error("self-powered ports not at 500 mA");
   AST_BUS_ENC: assert property (@(posedge ref_clk) disable iff (!rstn) // see R6
      !power_source_select |-> port_current_ma != 16'h01F4)
      else $error("bus-powered encoding wrong");
   AST_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rstn) // see R4
      (cfg_wr && !addr_hit) |=> $stable(vendor_id) && $stable(product_id) && cfg_addr_err)
      else $error("unmapped write changed state");

   // ----------------------------------------
   // Identity mapping checks
   // ----------------------------------------
   AST_VID_HIGH_MAP: assert property (@(posedge ref_clk) disable iff (!rstn) // see R1
      (cfg_wr && cfg_addr == HICR_VENDOR_ID_HIGH_OFS) |=> vendor_id[15:8] == $past(cfg_wdata))
      else $error("vendor high byte misplaced");
   AST_PID_LOW_MAP: assert property (@(posedge ref_clk) disable iff (!rstn) // see R2
      (cfg_wr && cfg_addr == HICR_PRODUCT_ID_LOW_OFS) |=> product_id[7:0] == $past(cfg_wdata))
      else $error("product low byte misplaced");
   AST_REL_LOW_MAP: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
      (cfg_wr && cfg_addr == HICR_RELEASE_NUMBER_LOW_OFS && wdata_bcd_ok) |=>
      release_number[7:0] == $past(cfg_wdata))
      else $error("release low byte misplaced");
   AST_REL_HIGH_MAP: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
      (cfg_wr && cfg_addr == HICR_RELEASE_NUMBER_HIGH_OFS && wdata_bcd_ok) |=>
      release_number[15:8] == $past(cfg_wdata))
      else $error("release high byte misplaced");

   // ----------------------------------------
   // Read-back, error flag and identity hold checks
   // ----------------------------------------
   AST_RD_DATA: assert property (@(posedge ref_clk) disable iff (!rstn) // see R4
      (cfg_rd && addr_hit) |=> cfg_rdata == $past(regs_reg[wr_idx]))
      else $error("read data not the stored byte");
   AST_RD_UNMAPPED: assert property (@(posedge ref_clk) disable iff (!rstn) // see R4
      (cfg_rd && !addr_hit) |=> cfg_rdata == 8'h00 && cfg_addr_err)
      else $error("unmapped read not zero");
   AST_ERR_QUIET: assert property (@(posedge ref_clk) disable iff (!rstn) // see R4
      !(cfg_wr || cfg_rd) |=> !cfg_addr_err && !cfg_bcd_err)
      else $error("error flag without an access");
   AST_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn) // see R4
      !cfg_wr |=> $stable(vendor_id) && $stable(product_id) && $stable(release_number))
      else $error("identity changed without a write");

   // ----------------------------------------
   // Release digits and reset defaults
   // ----------------------------------------
   AST_BCD_TAKEN: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
      (cfg_wr && is_release && wdata_bcd_ok) |=>
      regs_reg[$past(wr_idx)] == $past(cfg_wdata) && !cfg_bcd_err)
      else $error("decimal release byte not stored");
   AST_RELEASE_BCD: assert property (@(posedge ref_clk) disable iff (!rstn) // see R3
      release_number[3:0] <= 4'h9 && release_number[7:4] <= 4'h9 &&
      release_number[11:8] <= 4'h9 && release_number[15:12] <= 4'h9)
      else $error("release number holds a non-decimal digit");
   // Looked at on the first edge after release, before any request can land
   for (genvar g = 0; g < HICR_NUM_REGS; g++) begin : g_def_chk
      AST_RESET_DEFAULT: assert property (@(posedge ref_clk) $rose(rstn) |-> // see R8
         regs_reg[g] == def_val(g))
         else $error("byte not at its default after reset");
   end
endmodule

/* hicr_regs_tb_top.sv */
// Self-checking bench for the hub identity and configuration register slice
`timescale 1ns/100ps
module hicr_regs_tb_top
   import hicr_pkg::*;
;
   logic ref_clk = 1'b0;
   logic rstn;
   logic cfg_wr, cfg_rd, cfg_addr_err, cfg_bcd_err, power_source_select;
   logic [7:0] cfg_addr, cfg_wdata, cfg_rdata;
   logic [15:0] vendor_id, product_id, release_number, port_current_ma;
   logic [2:0] port_available;
   int error_cnt = 0;
   int checks_done = 0;
   logic [7:0] def_tab [7] = '{HICR_DEF_VENDOR_ID_LOW, HICR_DEF_VENDOR_ID_HIGH,
      HICR_DEF_PRODUCT_ID_LOW, HICR_DEF_PRODUCT_ID_HIGH, HICR_DEF_RELEASE_NUMBER_LOW,
      HICR_DEF_RELEASE_NUMBER_HIGH, HICR_DEF_HUB_CONFIG_BYTE_ONE};
   logic [7:0] new_tab [7] = '{8'h34, 8'h12, 8'h78, 8'h56, 8'h99, 8'h10, 8'h00};
   hicr_cfg_master hicr_cfg_master_inst (.ref_clk(ref_clk), .cfg_wr(cfg_wr),
      .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
   hicr_regs #(.PORT_COUNT(3)) hicr_regs_inst (.ref_clk(ref_clk), .rstn(rstn),
      .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
      .cfg_rdata(cfg_rdata), .cfg_addr_err(cfg_addr_err), .cfg_bcd_err(cfg_bcd_err),
      .vendor_id(vendor_id), .product_id(product_id), .release_number(release_number),
      .power_source_select(power_source_select), .port_available(port_available),
      .port_current_ma(port_current_ma));
   initial forever #25 ref_clk = ~ref_clk;
   task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      hicr_cfg_master_inst.write_byte(a, d);
      #1;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      hicr_cfg_master_inst.read_byte(a);
      #1;
      chk("cfg_rdata", {8'h00, exp}, {8'h00, cfg_rdata});
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200000;
      error_cnt++;
      print_verdict;
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      // Driven from X at time zero so the asynchronous reset sees a real falling edge
      rstn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) rd_chk(8'(i), def_tab[i]);
      for (int i = 0; i < 7; i++) wr(8'(i), new_tab[i]);
      for (int i = 0; i < 7; i++) rd_chk(8'(i), new_tab[i]);
      chk("vendor_id", 16'h1234, vendor_id);
      chk("product_id", 16'h5678, product_id);
      chk("release_number", 16'h1099, release_number);
      chk("power_source_select", 16'h0000, {15'h0000, power_source_select});
      chk("port_current_ma", 16'h0064, port_current_ma);
      chk("port_available", 16'h0007, {13'h0000, port_available});
      wr(8'h04, 8'h4A);
      chk("cfg_bcd_err", 16'h0001, {15'h0000, cfg_bcd_err});
      wr(8'h05, 8'hA0);
      chk("cfg_bcd_err", 16'h0001, {15'h0000, cfg_bcd_err});
      chk("release_number", 16'h1099, release_number);
      wr(8'h04, 8'h42);
      chk("cfg_bcd_err", 16'h0000, {15'h0000, cfg_bcd_err});
      chk("release_number", 16'h1042, release_number);
      wr(8'h07, 8'h55);
      chk("cfg_addr_err", 16'h0001, {15'h0000, cfg_addr_err});
      rd_chk(8'h07, 8'h00);
      chk("cfg_addr_err", 16'h0001, {15'h0000, cfg_addr_err});
      chk("vendor_id", 16'h1234, vendor_id);
      wr(8'h06, 8'h80);
      chk("power_source_select", 16'h0001, {15'h0000, power_source_select});
      chk("port_current_ma", 16'h01F4, port_current_ma);
      chk("port_available", 16'h0007, {13'h0000, port_available});
      // Second reset in mid-run must bring back every default
      @(posedge ref_clk);
      rstn <= 1'b0;
      @(posedge ref_clk);
      rstn <= 1'b1;
      for (int i = 0; i < 7; i++) rd_chk(8'(i), def_tab[i]);
      chk("vendor_id", {def_tab[1], def_tab[0]}, vendor_id);
      chk("power_source_select", {15'h0000, def_tab[6][7]}, {15'h0000, power_source_select});
      print_verdict;
   end
endmodule
